// ===== logic/dacdc_top.sv
/*
  Playback DAC digital control registers, zero flag pins and left peak
  level detector. Assumes a control port engine outside that presents
  decoded one-cycle write and read strobes with a 7-bit register address,
  and a datapath that supplies mute state and processed samples.
*/
// Functional notes
// (RULE1) Divider field derives working clock from master
// (RULE2) Interpolator field sets ratio; code 11 reserved
// (RULE3) De-emphasis field selects none, 44.1, 32, 48
// (RULE4) Mute or zero volume raises flag unless disabled
// (RULE5) Zero input data raises flag unless disabled
// (RULE6) Polarity bit sets flag pins active level
// (RULE7) Shared pin: left flag or interrupt output
// (RULE8) In interrupt mode selector defines right pin
// (RULE9) Per-channel 8-bit volume, 0.375 dB steps
// (RULE10) Left peak as 6-bit code, 1 dB steps
// (RULE11) Registers sit at addresses 0x65 through 0x6A
// (RULE12) Reserved bits read zero, writes ignored
// (RULE13) Peak register read-only, updated from samples
`timescale 1ns/1ps
module dacdc_top
  import dacdc_pkg::*;
#(
  parameter int SAMPLE_W    = 24,
  parameter int PEAK_WINDOW = 1024
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                wr_en,
  input  wire logic [6:0]          wr_addr,
  input  wire logic [7:0]          wr_data,
  input  wire logic                rd_en,
  input  wire logic [6:0]          rd_addr,
  output logic      [7:0]          rd_data,
  output logic                     rd_valid,
  input  wire logic                mute_left,
  input  wire logic                mute_right,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] left_sample,
  input  wire logic [SAMPLE_W-1:0] right_sample,
  input  wire logic                irq_in,
  output logic                     left_flag_irq_pin,
  output logic                     right_silence_flag,
  output logic      [1:0]          deemphasis_sel,
  output logic      [1:0]          interp_ratio_sel,
  output logic      [7:0]          left_volume_code,
  output logic      [7:0]          right_volume_code,
  output logic                     work_clk_en,
  output logic                     sample_tick
);
  localparam int MAG_W = SAMPLE_W - 1;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  zcfg;
    logic [7:0]  pinf;
    logic [7:0]  voll;
    logic [7:0]  volr;
    logic [5:0]  peak;
    logic [MAG_W-1:0] peak_max;
    logic [15:0] win_cnt;
    logic        zdata_l;
    logic        zdata_r;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        pin_l;
    logic        pin_r;
  } dacdc_state_t;

  dacdc_state_t s_q, s_d;
  logic [MAG_W-1:0] mag;
  logic [MAG_W-1:0] win_max;
  logic [MAG_W-1:0] norm;
  logic [6:0]       lz;
  logic             lz_found;
  logic [2:0]       mant;
  logic [6:0]       db;
  logic [2:0]       frac_db;
  logic             zl, zr, vdis, ddis, pol, irq_mode, rsel_flag;
  logic [1:0]       rsel;

  dacdc_clk_gen dacdc_clk_gen_inst (
    .clk                   (clk),
    .rst                   (rst),
    .dac_clock_divider_sel (s_q.cfg[DIV_LSB +: 2]),
    .interp_ratio_sel      (s_q.cfg[INTERP_LSB +: 2]),
    .work_clk_en           (work_clk_en),
    .sample_tick           (sample_tick)
  );

  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;

    // Register writes; reserved bits are masked off at the door
    if (wr_en) begin
      case (wr_addr)
        ADDR_CLOCK_FILTER_CFG: s_d.cfg  = wr_data & MASK_CLOCK_FILTER_CFG; // RULE12
        ADDR_ZERO_FLAG_CFG:    s_d.zcfg = wr_data & MASK_ZERO_FLAG_CFG; // RULE12
        ADDR_FLAG_PIN_FUNC:    s_d.pinf = wr_data & MASK_FLAG_PIN_FUNC; // RULE12
        ADDR_LEFT_VOLUME:      s_d.voll = wr_data; // RULE9
        ADDR_RIGHT_VOLUME:     s_d.volr = wr_data; // RULE11
        default:               s_d.cfg  = s_q.cfg; // Peak and unmapped ignored RULE13
      endcase
    end

    // Reads answer one cycle later; unmapped addresses read zero
    if (rd_en) begin
      s_d.rd_valid = 1'b1;
      case (rd_addr)
        ADDR_CLOCK_FILTER_CFG: s_d.rd_data = s_q.cfg; // RULE11
        ADDR_ZERO_FLAG_CFG:    s_d.rd_data = s_q.zcfg;
        ADDR_FLAG_PIN_FUNC:    s_d.rd_data = s_q.pinf;
        ADDR_LEFT_VOLUME:      s_d.rd_data = s_q.voll;
        ADDR_RIGHT_VOLUME:     s_d.rd_data = s_q.volr;
        ADDR_LEFT_PEAK:        s_d.rd_data = {2'b00, s_q.peak} & MASK_LEFT_PEAK; // RULE12
        default:               s_d.rd_data = 8'h00;
      endcase
    end

    // Magnitude of the left sample; full negative saturates
    mag = left_sample[SAMPLE_W-1] ? MAG_W'(~left_sample + 1'b1) : left_sample[MAG_W-1:0];
    if (left_sample[SAMPLE_W-1] && (left_sample[MAG_W-1:0] == '0)) begin
      mag = '1;
    end

    // Window maximum including this sample; dB is derived before publishing
    win_max = s_q.peak_max;
    if (sample_valid && mag > s_q.peak_max) begin
      win_max = mag;
    end

    // Approximate dB: six per leading zero plus a sub-octave step
    lz = 7'h00;
    lz_found = 1'b0;
    for (int i = MAG_W - 1; i >= 0; i--) begin
      if (win_max[i]) begin
        lz_found = 1'b1;
      end else if (!lz_found) begin
        lz = lz + 7'h01;
      end
    end
    // Normalising shift keeps the mantissa select inside the vector
    norm = win_max << lz;
    mant = norm[MAG_W-2 -: 3];
    case (mant)
      3'h0: frac_db = 3'h6;
      3'h1: frac_db = 3'h5;
      3'h2: frac_db = 3'h4;
      3'h3, 3'h4: frac_db = 3'h3;
      3'h5: frac_db = 3'h2;
      default: frac_db = 3'h1;
    endcase
    db = (lz >= 7'h0B) ? 7'(PEAK_FLOOR) : 7'(lz * DB_PER_OCTAVE) + {4'h0, frac_db}; // RULE10
    if (mant == 3'h7 && lz == 7'h00) begin
      db = 7'h00;
    end

    // Peak hold over a window, then publish and restart empty
    if (sample_valid) begin
      s_d.zdata_l  = (left_sample == '0); // RULE5
      s_d.zdata_r  = (right_sample == '0); // RULE5
      s_d.peak_max = win_max;
      if (s_q.win_cnt >= 16'(PEAK_WINDOW - 1)) begin
        s_d.win_cnt  = 16'h0000;
        s_d.peak     = db[6] ? PEAK_FLOOR : 6'(db > 7'(PEAK_FLOOR) ? 7'(PEAK_FLOOR) : db); // RULE13
        s_d.peak_max = '0;
      end else begin
        s_d.win_cnt = s_q.win_cnt + 16'h0001;
      end
    end

    // Zero flag causes per channel
    vdis = s_q.zcfg[VOLDIS_BIT];
    ddis = s_q.zcfg[DATADIS_BIT];
    pol  = s_q.zcfg[POL_BIT];
    zl = (!vdis && (mute_left || s_q.voll == 8'h00)) || (!ddis && s_q.zdata_l); // RULE4 RULE5
    zr = (!vdis && (mute_right || s_q.volr == 8'h00)) || (!ddis && s_q.zdata_r); // RULE4 RULE5
    irq_mode = s_q.pinf[IRQ_BIT];
    rsel = s_q.pinf[RSEL_LSB +: 2];
    case (rsel)
      RSEL_LEFT: rsel_flag = zl; // RULE8
      RSEL_ANY:  rsel_flag = zl | zr; // RULE8
      RSEL_BOTH: rsel_flag = zl & zr; // RULE8
      default:   rsel_flag = zr;
    endcase
    s_d.pin_l = irq_mode ? irq_in : (zl ^ pol); // RULE7 RULE6
    s_d.pin_r = (irq_mode ? rsel_flag : zr) ^ pol; // RULE6
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.voll     <= RST_VOLUME;
      s_q.volr     <= RST_VOLUME;
      s_q.cfg      <= RST_CFG;
      s_q.peak     <= PEAK_FLOOR;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign rd_data            = s_q.rd_data;
  assign rd_valid           = s_q.rd_valid;
  assign left_flag_irq_pin  = s_q.pin_l;
  assign right_silence_flag = s_q.pin_r;
  assign deemphasis_sel     = s_q.cfg[DEEM_LSB +: 2]; // RULE3
  assign interp_ratio_sel   = s_q.cfg[INTERP_LSB +: 2]; // RULE2
  assign left_volume_code   = s_q.voll; // RULE9
  assign right_volume_code  = s_q.volr;

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // RULE12
    rd_en && rd_addr == ADDR_ZERO_FLAG_CFG |=> rd_valid && rd_data[7:3] == 5'h00)
    else $error("reserved bits read non-zero");
  a_peak_readonly: assert property (@(posedge clk) disable iff (rst) // RULE13
    wr_en && wr_addr == ADDR_LEFT_PEAK && !sample_valid |=> $stable(s_q.peak))
    else $error("peak register changed by host write");
  a_volume_store: assert property (@(posedge clk) disable iff (rst) // RULE9
    wr_en && wr_addr == ADDR_LEFT_VOLUME |=> left_volume_code == $past(wr_data))
    else $error("left volume not stored");
  a_right_vol_addr: assert property (@(posedge clk) disable iff (rst) // RULE11
    wr_en && wr_addr == ADDR_RIGHT_VOLUME ##1 rd_en && rd_addr == ADDR_RIGHT_VOLUME && !wr_en
    |=> rd_data == $past(wr_data, 2))
    else $error("right volume readback wrong");
  a_mute_flag: assert property (@(posedge clk) disable iff (rst) // RULE4
    !irq_mode && !vdis && mute_right |=> right_silence_flag == !$past(pol))
    else $error("mute did not raise right flag");
  a_irq_pass: assert property (@(posedge clk) disable iff (rst) // RULE7
    irq_mode |=> left_flag_irq_pin == $past(irq_in))
    else $error("shared pin not following interrupt");
  a_both_select: assert property (@(posedge clk) disable iff (rst) // RULE8
    irq_mode && rsel == RSEL_BOTH && !(zl && zr) |=> right_silence_flag == $past(pol))
    else $error("both-zero selector asserted wrongly");
  a_data_disable: assert property (@(posedge clk) disable iff (rst) // RULE5
    !irq_mode && ddis && vdis |=> right_silence_flag == $past(pol))
    else $error("disabled zero flag asserted");
  a_peak_range: assert property (@(posedge clk) disable iff (rst) // RULE10
    rd_valid && $past(rd_addr) == ADDR_LEFT_PEAK |-> rd_data[7:6] == 2'b00)
    else $error("peak code exceeds six bits");
endmodule : dacdc_top

// ===== logic/dacdc_pkg.sv
/*
  Constants for the playback DAC digital control block: register map,
  field positions, reset values, divider and interpolator encodings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dacdc_pkg;
  // Register addresses on the 7-bit control port
  localparam logic [6:0] ADDR_CLOCK_FILTER_CFG = 7'h65;
  localparam logic [6:0] ADDR_ZERO_FLAG_CFG    = 7'h66;
  localparam logic [6:0] ADDR_FLAG_PIN_FUNC    = 7'h67;
  localparam logic [6:0] ADDR_LEFT_VOLUME      = 7'h68;
  localparam logic [6:0] ADDR_RIGHT_VOLUME     = 7'h69;
  localparam logic [6:0] ADDR_LEFT_PEAK        = 7'h6A;

  // Writable bit masks, plus the peak read mask; everything else reads zero
  localparam logic [7:0] MASK_CLOCK_FILTER_CFG = 8'h3F;
  localparam logic [7:0] MASK_ZERO_FLAG_CFG    = 8'h07;
  localparam logic [7:0] MASK_FLAG_PIN_FUNC    = 8'h70;
  localparam logic [7:0] MASK_LEFT_PEAK        = 8'h3F;

  // Field positions
  localparam int DIV_LSB   = 4;
  localparam int INTERP_LSB = 2;
  localparam int DEEM_LSB  = 0;
  localparam int VOLDIS_BIT = 2;
  localparam int DATADIS_BIT = 1;
  localparam int POL_BIT   = 0;
  localparam int IRQ_BIT   = 6;
  localparam int RSEL_LSB  = 4;

  // Reset values
  localparam logic [7:0] RST_CFG    = 8'h00;
  localparam logic [7:0] RST_VOLUME = 8'hFF;
  localparam logic [5:0] PEAK_FLOOR = 6'h3F;

  // Master clock divider codes
  localparam logic [1:0] DIV_NONE  = 2'h0;
  localparam logic [1:0] DIV_1P5   = 2'h1;
  localparam logic [1:0] DIV_TWO   = 2'h2;
  localparam logic [1:0] DIV_THREE = 2'h3;

  // Interpolator codes and working clocks per sample, minus one
  localparam logic [1:0] INTERP_8X = 2'h0;
  localparam logic [1:0] INTERP_4X = 2'h1;
  localparam logic [1:0] INTERP_2X = 2'h2;
  localparam logic [7:0] CLKS_8X_M1 = 8'hFF;
  localparam logic [7:0] CLKS_4X_M1 = 8'h7F;
  localparam logic [7:0] CLKS_2X_M1 = 8'h3F;

  // Right flag pin selector codes
  localparam logic [1:0] RSEL_RIGHT = 2'h0;
  localparam logic [1:0] RSEL_LEFT  = 2'h1;
  localparam logic [1:0] RSEL_ANY   = 2'h2;
  localparam logic [1:0] RSEL_BOTH  = 2'h3;

  // Peak detector: dB step per octave
  localparam logic [6:0] DB_PER_OCTAVE = 7'h06;
endpackage : dacdc_pkg

// ===== logic/dacdc_clk_gen.sv
/*
  Working clock enable and sample strobe generator for the DAC.
  Assumes clk is the DAC master clock and the selectors are quasi-static.
*/
`timescale 1ns/1ps
module dacdc_clk_gen
  import dacdc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] dac_clock_divider_sel,
  input  wire logic [1:0] interp_ratio_sel,
  output logic            work_clk_en,
  output logic            sample_tick
);
  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] clk_cnt;
    logic       en;
    logic       tick;
  } dacdc_gen_t;

  dacdc_gen_t s_q, s_d;
  logic [1:0] phase_wrap;
  logic [7:0] cnt_top;

  // Divider phase pattern; 1.5 gives two enables in every three clocks
  always_comb begin
    s_d = s_q;
    phase_wrap = (dac_clock_divider_sel == DIV_TWO) ? 2'h1 : 2'h2;
    case (interp_ratio_sel)
      INTERP_4X: cnt_top = CLKS_4X_M1;
      INTERP_2X: cnt_top = CLKS_2X_M1;
      default:   cnt_top = CLKS_8X_M1; // Reserved code runs as 8x
    endcase
    s_d.phase = (s_q.phase >= phase_wrap) ? 2'h0 : s_q.phase + 2'h1;
    case (dac_clock_divider_sel)
      DIV_NONE: s_d.en = 1'b1; // RULE1
      DIV_1P5:  s_d.en = (s_d.phase != 2'h2); // RULE1
      default:  s_d.en = (s_d.phase == 2'h0); // RULE1
    endcase
    s_d.tick = 1'b0;
    if (s_d.en) begin
      if (s_q.clk_cnt >= cnt_top) begin
        s_d.clk_cnt = 8'h00;
        s_d.tick    = 1'b1; // RULE2
      end else begin
        s_d.clk_cnt = s_q.clk_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign work_clk_en = s_q.en;
  assign sample_tick = s_q.tick;

  // Selector must hold through the gap, a new code legally restarts the pattern
  sequence three_hold_seq;
    (dac_clock_divider_sel == DIV_THREE) [*4] ##0 work_clk_en ##1
      (dac_clock_divider_sel == DIV_THREE) [*2];
  endsequence

  sequence three_gap_seq;
    !$past(work_clk_en) && !work_clk_en ##1 work_clk_en;
  endsequence

  a_div_by_three: assert property (@(posedge clk) disable iff (rst) // RULE1
    three_hold_seq |-> three_gap_seq)
    else $error("divide by three pattern broken");
  a_div_by_two: assert property (@(posedge clk) disable iff (rst) // RULE1
    (dac_clock_divider_sel == DIV_TWO) [*3] ##0 work_clk_en ##1
    (dac_clock_divider_sel == DIV_TWO) |-> !work_clk_en ##1 work_clk_en)
    else $error("divide by two pattern broken");
  a_div_one_half: assert property (@(posedge clk) disable iff (rst) // RULE1
    (dac_clock_divider_sel == DIV_1P5) [*4] |-> ($countones({work_clk_en,
      $past(work_clk_en), $past(work_clk_en, 2)}) == 2))
    else $error("divide by 1.5 density wrong");
  a_tick_on_enable: assert property (@(posedge clk) disable iff (rst) // RULE2
    sample_tick |-> work_clk_en)
    else $error("sample tick without working clock");
endmodule : dacdc_clk_gen

// ===== bench/dacdc_host_model.sv
/*
  Host side of the control port: one-cycle write and read strobes.
  Assumes the bench clock; strobes change only at the falling edge.
*/
`timescale 1ns/1ps
module dacdc_host_model (
  input  wire logic       clk,
  output logic            wr_en,
  output logic      [6:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic            rd_en,
  output logic      [6:0] rd_addr
);
  // Idle port at time zero
  initial begin
    wr_en   = 1'b0;
    wr_addr = 7'h00;
    wr_data = 8'h00;
    rd_en   = 1'b0;
    rd_addr = 7'h00;
  end

  // Released lines show the inverse, so a stale value never looks fresh
  task automatic write(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en   = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask : write

  // Write, then read the same place in the very next cycle
  task automatic write_read(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en   = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en   = 1'b0;
    rd_addr = ~a;
  endtask : write_read

  // Read strobe for one cycle; data is collected by the bench monitor
  task automatic read(input logic [6:0] a);
    @(negedge clk);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en   = 1'b0;
    rd_addr = ~a;
  endtask : read
endmodule : dacdc_host_model

// ===== bench/dac_digital_control_bench.sv
/*
  Self-checking bench for the DAC control registers and flag pins.
  Assumes the host model for the port and a 125 MHz clock.
*/
`timescale 1ns/1ps
module dac_digital_control_bench;
  import dacdc_pkg::*;
  logic        clk, rst, wr_en, rd_en, rd_valid, mute_left, mute_right;
  logic        sample_valid, irq_in, left_flag_irq_pin, right_silence_flag;
  logic        work_clk_en, sample_tick;
  logic [6:0]  wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data, left_volume_code, right_volume_code;
  logic [1:0]  deemphasis_sel, interp_ratio_sel;
  logic [23:0] left_sample, right_sample;
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [7:0]  exp_q [$];
  logic [7:0]  rst_tbl [6] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h3F};
  logic [7:0]  wr_tbl [6]  = '{8'hDB, 8'hFF, 8'hFF, 8'h00, 8'hA5, 8'h00};
  logic [7:0]  rb_tbl [6]  = '{8'h1B, 8'h07, 8'h70, 8'h00, 8'hA5, 8'h3F};
  int          en_tbl [4]  = '{12, 8, 6, 4};

  dacdc_top #(.SAMPLE_W(24), .PEAK_WINDOW(8)) dacdc_top_inst (
    .clk                (clk),
    .rst                (rst),
    .wr_en              (wr_en),
    .wr_addr            (wr_addr),
    .wr_data            (wr_data),
    .rd_en              (rd_en),
    .rd_addr            (rd_addr),
    .rd_data            (rd_data),
    .rd_valid           (rd_valid),
    .mute_left          (mute_left),
    .mute_right         (mute_right),
    .sample_valid       (sample_valid),
    .left_sample        (left_sample),
    .right_sample       (right_sample),
    .irq_in             (irq_in),
    .left_flag_irq_pin  (left_flag_irq_pin),
    .right_silence_flag (right_silence_flag),
    .deemphasis_sel     (deemphasis_sel),
    .interp_ratio_sel   (interp_ratio_sel),
    .left_volume_code   (left_volume_code),
    .right_volume_code  (right_volume_code),
    .work_clk_en        (work_clk_en),
    .sample_tick        (sample_tick)
  );
  dacdc_host_model dacdc_host_model_inst (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_en   (rd_en),
    .rd_addr (rd_addr)
  );

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic results();
    $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    dacdc_host_model_inst.write(a, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    dacdc_host_model_inst.read(a);
  endtask : rd

  // Pins are registered, so allow the write and one more edge to land
  task automatic pins(input logic l, input logic r);
    repeat (2) @(negedge clk);
    check_val(16'({left_flag_irq_pin, right_silence_flag}), 16'({l, r}));
  endtask : pins

  task automatic send(input logic [23:0] l, input logic [23:0] r);
    @(negedge clk);
    left_sample  = l;
    right_sample = r;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    left_sample  = ~l;
    right_sample = ~r;
  endtask : send

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sample_tick !== 1'b1 && n < 600);
    if (n >= 600) begin
      fail_count++;
      results();
    end
  endtask : wait_tick

  // Read monitor: each read answer takes the oldest expectation
  always @(negedge clk) begin
    if (rd_valid === 1'b1)
      check_reg(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    int n;
    int cnt;
    rst = 1'b1;
    {mute_left, mute_right, sample_valid, irq_in} = 4'h0;
    left_sample  = 24'h000001;
    right_sample = 24'h000001;
    void'($urandom(32'hB9A4016E));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    // Reset values, masked writes, peak write ignored, unmapped place
    wr_tbl[3] = 8'($urandom);
    rb_tbl[3] = wr_tbl[3];
    for (int a = 0; a < 6; a++) rd(ADDR_CLOCK_FILTER_CFG + 7'(a), rst_tbl[a]);
    for (int a = 0; a < 6; a++) wr(ADDR_CLOCK_FILTER_CFG + 7'(a), wr_tbl[a]);
    for (int a = 0; a < 6; a++) rd(ADDR_CLOCK_FILTER_CFG + 7'(a), rb_tbl[a]);
    check_val(16'(left_volume_code), 16'(wr_tbl[3]));
    check_val(16'(right_volume_code), 16'h00A5);
    wr(7'h40, 8'h5A);
    rd(7'h40, 8'h00);
    // Divider codes: enables in 12 cycles; de-emphasis follows same code
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CLOCK_FILTER_CFG, {2'b00, 2'(i), 2'b00, 2'(i)});
      repeat (6) @(negedge clk);
      cnt = 0;
      repeat (12) begin
        @(negedge clk);
        cnt += int'(work_clk_en === 1'b1);
      end
      check_val(16'(cnt), 16'(en_tbl[i]));
      check_val(16'(deemphasis_sel), 16'(i));
    end
    // Interpolator codes; reserved code 11 is never written
    for (int j = 0; j < 3; j++) begin
      wr(ADDR_CLOCK_FILTER_CFG, {4'h0, 2'(j), 2'b00});
      repeat (2) wait_tick(n);
      wait_tick(n);
      check_val(16'(n), 16'(256 >> j));
      check_val(16'(interp_ratio_sel), 16'(j));
    end
    // Zero flag causes, enables and polarity
    wr(ADDR_ZERO_FLAG_CFG, 8'h00);
    wr(ADDR_FLAG_PIN_FUNC, 8'h00);
    wr(ADDR_LEFT_VOLUME, 8'hFF);
    wr(ADDR_RIGHT_VOLUME, 8'hFF);
    send({1'b0, 22'($urandom), 1'b1}, 24'h000100);
    pins(1'b0, 1'b0);
    mute_left = 1'b1;
    pins(1'b1, 1'b0);
    mute_right = 1'b1;
    pins(1'b1, 1'b1);
    wr(ADDR_ZERO_FLAG_CFG, 8'h04);
    pins(1'b0, 1'b0);
    {mute_left, mute_right} = 2'b00;
    wr(ADDR_ZERO_FLAG_CFG, 8'h00);
    wr(ADDR_RIGHT_VOLUME, 8'h00);
    pins(1'b0, 1'b1);
    exp_q.push_back(8'hFF);
    dacdc_host_model_inst.write_read(ADDR_RIGHT_VOLUME, 8'hFF);
    send(24'h000000, 24'h000100);
    pins(1'b1, 1'b0);
    wr(ADDR_ZERO_FLAG_CFG, 8'h02);
    pins(1'b0, 1'b0);
    wr(ADDR_ZERO_FLAG_CFG, 8'h03);
    pins(1'b1, 1'b1);
    wr(ADDR_ZERO_FLAG_CFG, 8'h01);
    pins(1'b0, 1'b1);
    wr(ADDR_ZERO_FLAG_CFG, 8'h00);
    // Interrupt mode: left zero only, so selectors give 0,1,1,0
    for (int s = 0; s < 4; s++) begin
      irq_in = s[0];
      wr(ADDR_FLAG_PIN_FUNC, {2'b01, 2'(s), 4'h0});
      pins(s[0], s == 1 || s == 2);
    end
    wr(ADDR_FLAG_PIN_FUNC, 8'h00);
    pins(1'b1, 1'b0);
    // Peak level: two windows full scale, then two windows of silence
    repeat (16) send(24'h7FFFFF, 24'h000100);
    repeat (4) @(negedge clk);
    rd(ADDR_LEFT_PEAK, 8'h00);
    repeat (16) send(24'h000000, 24'h000100);
    repeat (4) @(negedge clk);
    rd(ADDR_LEFT_PEAK, 8'h3F);
    repeat (4) @(negedge clk);
    check_val(16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule : dac_digital_control_bench
